// *** verilog/modbus_slave_fe.sv ***
// How it works
// - Station address is settable 1 to 247; only own-address and broadcast queries are served.
// - Address zero is broadcast and is accepted as a query.
// - A valid query either returns the register or performs the write.
// - Serial bit rate is one of 1200, 2400, 4800, 9600, 19200.
// - Every serial character uses the set parity: none, even or odd.
// - All data lives in 16-bit read-write holding registers.
// - Reference 40xxxx selects holding register at address xxxx.
// - Each port has a protocol setting: none, Modbus, IEC 61850, EtherNet/IP, DNP3.
// - Network port defaults to 502, or 44818 with EtherNet/IP.
// - One transaction engine serves both TCP and RTU.
// - TCP requests must match both station address and TCP port.
// - Modbus is served on a port only when its protocol is Modbus.
// - IEC 61850 is selectable only on units built with that option.
`include "mb_consts.svh"
module modbus_slave_fe
  import mb_pkg::*;
#(
  parameter int unsigned ClkHz     = `MB_CLK_HZ,     // System clock rate in Hz.
  parameter int unsigned TcpToutUs = `MB_TCP_TOUT_US // Reply hand-off limit in us.
) (
  input  wire logic        mclk,        // System clock.
  input  wire logic        rstn,        // Synchronous reset.
  input  wire logic        wbCyc,       // Bus cycle.
  input  wire logic        wbStb,       // Bus strobe.
  input  wire logic        wbWe,        // Write enable.
  input  wire logic [7:0]  wbAdr,       // Byte address.
  input  wire logic [3:0]  wbSel,       // Byte lanes.
  input  wire logic [31:0] wbDatI,      // Write data.
  output logic      [31:0] wbDatO,      // Read data.
  output logic             wbAck,       // Acknowledge.
  input  wire logic        iecOption,   // Unit built with IEC 61850.
  input  wire logic        rtuRxd,      // Serial receive line.
  output logic             rtuTxd,      // Serial transmit line.
  output logic             rtuTxEn,     // Line driver enable.
  input  wire logic        tcpReqValid, // Request from the stack.
  output logic             tcpReqReady, // Engine can take it.
  input  wire tcp_req_t    tcpReq,      // Request fields.
  output logic             tcpRspValid, // Reply for the stack.
  input  wire logic        tcpRspReady, // Stack takes the reply.
  output tcp_rsp_t         tcpRsp       // Reply fields.
);
  localparam logic [23:0] ToutCyc = 24'(ClkHz / 1000000 * TcpToutUs);

  state_t q;
  state_t s;
  job_t job;
  logic serEval;
  logic [2:0] msgInc;
  logic [2:0] errInc;
  logic [2:0] toutInc;
  logic [23:0] bitCyc;
  logic [23:0] gapCyc;

  function automatic logic [15:0] crcStep(logic [15:0] c, logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MB_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic parBit(parity_t p, logic [7:0] b);
    return (p == PAR_ODD) ? ~^b : ^b;
  endfunction

  function automatic logic [23:0] bitLen(logic [2:0] sel);
    logic [31:0] baud;
    case (sel)
      3'h0: baud = `MB_BAUD0;
      3'h1: baud = `MB_BAUD1;
      3'h2: baud = `MB_BAUD2;
      3'h4: baud = `MB_BAUD4;
      default: baud = `MB_BAUD3;
    endcase
    return 24'(ClkHz / baud);
  endfunction

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] m);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (m[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic protoOk(logic [2:0] p, logic iec);
    return (p <= 3'(PR_DNP3)) && !(p == 3'(PR_IEC61850) && !iec);
  endfunction

  assign bitCyc = bitLen(q.baud);
  // Silence is counted in half bits so the fraction of a character is exact.
  // Counting starts at the stop-bit sample, so half a bit covers the rest of that bit.
  assign gapCyc = 24'(((32'(bitCyc) * `MB_GAP_HALFBITS + 32'h1) >> 1) + 32'(bitCyc >> 1));

  always_comb begin
    logic [31:0] w;
    logic [15:0] idx;
    logic [15:0] rd;
    logic [7:0] b;
    logic parOn;
    logic charDone;
    logic charBad;
    logic ok;
    logic [1:0] k;
    s = q;
    job = '0;
    serEval = 1'b0;
    msgInc = '0;
    errInc = '0;
    toutInc = '0;
    w = '0;
    idx = '0;
    rd = '0;
    b = '0;
    k = '0;
    charDone = 1'b0;
    charBad = 1'b0;
    ok = 1'b0;
    parOn = (q.parity != PAR_NONE);
    // Register bus: answer one cycle after the strobe, write on the ack edge.
    s.ack = wbCyc & wbStb & ~q.ack;
    if (wbCyc && wbStb && !q.ack) begin
      s.rdat = '0;
      if (wbAdr[7:6] == 2'b01) s.rdat = {16'h0000, q.hold[wbAdr[5:2]]};
      else if (wbAdr == `MB_OFF_CTRL)
        s.rdat = {16'h0000, q.serProto, q.parity, q.baud, q.station};
      else if (wbAdr == `MB_OFF_ETH0 || wbAdr == `MB_OFF_ETH1)
        s.rdat = {q.ethPort[wbAdr[3]], 13'h0000, q.ethProto[wbAdr[3]]};
      else if (wbAdr[7:4] != 4'h0 && wbAdr[7:4] <= 4'h3 && wbAdr[3:2] != 2'b11) begin
        k = 2'(wbAdr[5:4] - 2'b01);
        s.rdat = {16'h0000, wbAdr[3:2] == 2'b00 ? q.cnt[k].msg :
                  wbAdr[3:2] == 2'b01 ? q.cnt[k].err : q.cnt[k].tout};
      end
    end
    if (wbCyc && wbStb && wbWe && q.ack) begin
      if (wbAdr[7:6] == 2'b01) begin
        w = merge({16'h0000, q.hold[wbAdr[5:2]]}, wbDatI, wbSel);
        s.hold[wbAdr[5:2]] = w[15:0];
      end else if (wbAdr == `MB_OFF_CTRL) begin
        w = merge({16'h0000, q.serProto, q.parity, q.baud, q.station}, wbDatI, wbSel);
        if (w[7:0] >= `MB_ADDR_MIN && w[7:0] <= `MB_ADDR_MAX) s.station = w[7:0];
        if (w[10:8] <= 3'h4) s.baud = w[10:8];
        if (w[12:11] != 2'b11) s.parity = parity_t'(w[12:11]);
        if (protoOk(w[15:13], iecOption)) s.serProto = proto_t'(w[15:13]);
      end else if (wbAdr == `MB_OFF_ETH0 || wbAdr == `MB_OFF_ETH1) begin
        k = {1'b0, wbAdr[3]};
        w = merge({q.ethPort[k[0]], 13'h0000, q.ethProto[k[0]]}, wbDatI, wbSel);
        if (protoOk(w[2:0], iecOption)) begin
          s.ethProto[k[0]] = proto_t'(w[2:0]);
          if (w[2:0] != 3'(q.ethProto[k[0]]))
            s.ethPort[k[0]] = (w[2:0] == 3'(PR_ENIP)) ? `MB_PORT_ENIP : `MB_PORT_DEF;
          else
            s.ethPort[k[0]] = w[31:16];
        end
      end
    end
    // Serial receiver: half a bit to the start centre, then whole bits.
    case (q.rx)
      RX_IDLE: begin
        if (!rtuRxd) begin
          s.rx = RX_BITS;
          s.rxTmr = bitCyc >> 1;
          s.rxIdx = 4'h0;
          s.rxBad = 1'b0;
        end
      end
      RX_BITS: begin
        if (q.rxTmr != 24'h0) s.rxTmr = q.rxTmr - 24'h1;
        else begin
          s.rxTmr = bitCyc - 24'h1;
          s.rxIdx = q.rxIdx + 4'h1;
          if (q.rxIdx == 4'h0 && rtuRxd) s.rx = RX_IDLE;
          else if (q.rxIdx >= 4'h1 && q.rxIdx <= 4'h8) s.rxSh = {rtuRxd, q.rxSh[7:1]};
          else if (q.rxIdx == 4'h9 && parOn) s.rxBad = (rtuRxd != parBit(q.parity, q.rxSh));
          if (q.rxIdx == (parOn ? 4'ha : 4'h9)) begin
            s.rx = RX_IDLE;
            charDone = 1'b1;
            charBad = q.rxBad | ~rtuRxd;
          end
        end
      end
      default: s.rx = RX_IDLE;
    endcase
    if (charDone) begin
      if (q.fcnt < `MB_REQ_LEN) s.fbuf[q.fcnt[2:0]] = q.rxSh;
      if (q.fcnt != 4'h9) s.fcnt = q.fcnt + 4'h1;
      s.fCrc = crcStep(q.fCrc, q.rxSh);
      s.fErr = q.fErr | charBad;
    end
    if (q.rx != RX_IDLE || !rtuRxd) s.idle = 24'h0;
    else if (q.idle < gapCyc) s.idle = q.idle + 24'h1;
    if (q.fcnt != 4'h0 && q.idle >= gapCyc) begin
      s.fcnt = 4'h0;
      s.fErr = 1'b0;
      s.fCrc = `MB_CRC_INIT;
      if (q.serProto == PR_MODBUS) begin
        serEval = 1'b1;
        if (q.fErr) errInc[0] = 1'b1;
        else if (q.fcnt < `MB_REQ_LEN) toutInc[0] = 1'b1;
        else if (q.fcnt > `MB_REQ_LEN || q.fCrc != 16'h0000) errInc[0] = 1'b1;
        else if (q.fbuf[0] == q.station || q.fbuf[0] == `MB_ADDR_BCAST) begin
          job = '{1'b1, q.fbuf[0] == `MB_ADDR_BCAST, 2'b00, q.fbuf[1],
                  {q.fbuf[2], q.fbuf[3]}, {q.fbuf[4], q.fbuf[5]}};
          msgInc[0] = 1'b1;
        end
      end
    end
    // Network requests wait while a serial job or an unsent reply holds the engine.
    tcpReqReady = !job.vld && !q.rspV;
    if (tcpReqValid && tcpReqReady) begin
      k = {1'b0, tcpReq.inst};
      if (q.ethProto[k[0]] == PR_MODBUS && tcpReq.port == q.ethPort[k[0]] &&
          (tcpReq.unit == q.station || tcpReq.unit == `MB_ADDR_BCAST)) begin
        job = '{1'b1, tcpReq.unit == `MB_ADDR_BCAST, 2'(k + 2'b01), tcpReq.fc,
                tcpReq.addr, tcpReq.data};
        msgInc[k + 2'b01] = 1'b1;
      end
    end
    // Shared transaction engine for both transports.
    if (job.vld) begin
      idx = job.addr - `MB_HOLD_BASE;
      ok = (idx < 16'h0010) && (job.fc == `MB_FC_WRITE ||
           (job.fc == `MB_FC_READ && job.data == 16'h0001));
      if (!ok) errInc[job.src] = 1'b1;
      else begin
        if (job.fc == `MB_FC_WRITE) s.hold[idx[3:0]] = job.data;
        rd = (job.fc == `MB_FC_WRITE) ? job.data : q.hold[idx[3:0]];
        if (!job.bcast && job.src == 2'b00 && q.tx == TX_IDLE) begin
          s.txBuf = q.fbuf;
          s.txLen = `MB_REQ_LEN;
          if (job.fc == `MB_FC_READ) begin
            s.txBuf[2] = 8'h02;
            s.txBuf[3] = rd[15:8];
            s.txBuf[4] = rd[7:0];
            s.txLen = `MB_RD_RSP_LEN;
          end
          s.tx = TX_LOAD;
          s.txPos = 4'h0;
          s.txCrc = `MB_CRC_INIT;
          s.txEn = 1'b1;
        end else if (!job.bcast && job.src != 2'b00) begin
          s.rspV = 1'b1;
          s.rsp = '{job.src[1], job.fc, job.addr, rd};
          s.rspTmr = 24'h0;
        end
      end
    end
    // Serial transmitter; the check bytes are built while the body goes out.
    case (q.tx)
      TX_IDLE: s.txd = 1'b1;
      TX_LOAD: begin
        s.txd = 1'b1;
        if (q.txPos == q.txLen) begin
          s.tx = TX_IDLE;
          s.txEn = 1'b0;
        end else begin
          if (q.txPos < q.txLen - 4'h2) begin
            b = q.txBuf[q.txPos[2:0]];
            s.txCrc = crcStep(q.txCrc, b);
          end else b = (q.txPos == q.txLen - 4'h2) ? q.txCrc[7:0] : q.txCrc[15:8];
          s.txSh = parOn ? {1'b1, parBit(q.parity, b), b, 1'b0} : {2'b11, b, 1'b0};
          s.txBit = parOn ? 4'hb : 4'ha;
          s.txTmr = bitCyc - 24'h1;
          s.txPos = q.txPos + 4'h1;
          s.tx = TX_BITS;
        end
      end
      TX_BITS: begin
        s.txd = q.txSh[0];
        if (q.txTmr != 24'h0) s.txTmr = q.txTmr - 24'h1;
        else begin
          s.txTmr = bitCyc - 24'h1;
          s.txSh = {1'b1, q.txSh[10:1]};
          s.txBit = q.txBit - 4'h1;
          if (q.txBit == 4'h1) s.tx = TX_LOAD;
        end
      end
      default: s.tx = TX_IDLE;
    endcase
    // A reply the stack never takes is dropped and counted as a timeout.
    if (q.rspV) begin
      if (tcpRspReady) s.rspV = 1'b0;
      else if (q.rspTmr >= ToutCyc - 24'h1) begin
        s.rspV = 1'b0;
        toutInc[{1'b0, q.rsp.inst} + 2'b01] = 1'b1;
      end else s.rspTmr = q.rspTmr + 24'h1;
    end
    for (int i = 0; i < 3; i++) begin
      s.cnt[i].msg = q.cnt[i].msg + {15'h0000, msgInc[i]};
      s.cnt[i].err = q.cnt[i].err + {15'h0000, errInc[i]};
      s.cnt[i].tout = q.cnt[i].tout + {15'h0000, toutInc[i]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      q <= '0;
      q.station <= `MB_ADDR_RST;
      q.baud <= `MB_BAUD_RST;
      q.serProto <= PR_MODBUS;
      q.ethPort <= {`MB_PORT_DEF, `MB_PORT_DEF};
      q.fCrc <= `MB_CRC_INIT;
      q.txd <= 1'b1;
    end else begin
      q <= s;
    end
  end

  assign wbAck = q.ack;
  assign wbDatO = q.rdat;
  assign rtuTxd = q.txd;
  assign rtuTxEn = q.txEn;
  assign tcpRspValid = q.rspV;
  assign tcpRsp = q.rsp;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  ack_one_shot_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck)
    else $error("bus ack not a single cycle after strobe");
  station_range_a: assert property (q.station >= `MB_ADDR_MIN && q.station <= `MB_ADDR_MAX)
    else $error("station address out of range");
  foreign_frame_a: assert property (serEval && q.fbuf[0] != q.station &&
      q.fbuf[0] != `MB_ADDR_BCAST |-> !(job.vld && job.src == 2'b00))
    else $error("frame for another station was served");
  bcast_silent_a: assert property (job.vld && job.bcast && q.tx == TX_IDLE && !q.rspV
      |=> q.tx == TX_IDLE && !q.rspV)
    else $error("broadcast got a reply");
  bad_frame_a: assert property (serEval && q.fErr |-> !(job.vld && job.src == 2'b00) ##1
      q.cnt[0].err == $past(q.cnt[0].err) + 16'h0001)
    else $error("errored frame not dropped and counted");
  msg_count_a: assert property (job.vld && job.src == 2'b00 |=>
      q.cnt[0].msg == $past(q.cnt[0].msg) + 16'h0001)
    else $error("serial message count missed");
  enip_port_a: assert property (q.ethProto[1] != PR_ENIP ##1 q.ethProto[1] == PR_ENIP
      |-> q.ethPort[1] == `MB_PORT_ENIP)
    else $error("EtherNet/IP port default not loaded");
  iec_gate_a: assert property ($changed(q.ethProto[1]) && q.ethProto[1] == PR_IEC61850
      |-> $past(iecOption))
    else $error("IEC 61850 chosen without the option");
  tcp_proto_a: assert property ($rose(q.rspV) |->
      $past(q.ethProto[tcpReq.inst]) == PR_MODBUS && $past(tcpReqValid))
    else $error("reply from a port not set to Modbus");
  gap_end_a: assert property (serEval |-> q.rx == RX_IDLE && q.idle >= gapCyc
      ##1 q.fcnt == 4'h0)
    else $error("frame closed before the silent gap");
  write_apply_a: assert property (job.vld && job.fc == `MB_FC_WRITE &&
      job.addr < `MB_HOLD_BASE + 16'h0010 |=> q.hold[$past(job.addr[3:0])] == $past(job.data))
    else $error("holding register write lost");

  serial_read_c: cover property (job.vld && job.src == 2'b00 && job.fc == `MB_FC_READ);
  tcp_reply_c: cover property (q.rspV && tcpRspReady);
  parity_err_c: cover property (serEval && q.fErr);
  tcp_tout_c: cover property (toutInc[1]);
endmodule

// *** pkg/mb_consts.svh ***
`ifndef MB_CONSTS_SVH
`define MB_CONSTS_SVH
`define MB_CLK_HZ        40000000
`define MB_TCP_TOUT_US   1000
`define MB_GAP_HALFBITS  32'h0000004d
`define MB_BAUD0         32'h000004b0
`define MB_BAUD1         32'h00000960
`define MB_BAUD2         32'h000012c0
`define MB_BAUD3         32'h00002580
`define MB_BAUD4         32'h00004b00
`define MB_ADDR_MIN      8'h01
`define MB_ADDR_MAX      8'hf7
`define MB_ADDR_BCAST    8'h00
`define MB_ADDR_RST      8'h01
`define MB_BAUD_RST      3'h3
`define MB_PORT_DEF      16'h01f6
`define MB_PORT_ENIP     16'haf12
`define MB_CRC_INIT      16'hffff
`define MB_CRC_POLY      16'ha001
`define MB_FC_READ       8'h03
`define MB_FC_WRITE      8'h06
`define MB_HOLD_BASE     16'h0000
`define MB_REQ_LEN       4'h8
`define MB_RD_RSP_LEN    4'h7
`define MB_OFF_CTRL      8'h00
`define MB_OFF_ETH0      8'h04
`define MB_OFF_ETH1      8'h08
`endif

// *** pkg/mb_pkg.sv ***
`include "mb_consts.svh"
package mb_pkg;
  typedef enum logic [2:0] {PR_NONE, PR_MODBUS, PR_IEC61850, PR_ENIP, PR_DNP3} proto_t;
  typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_t;
  typedef enum logic {RX_IDLE, RX_BITS} rx_t;
  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_BITS} tx_t;
  typedef struct packed {
    logic        inst;
    logic [15:0] port;
    logic [7:0]  unit;
    logic [7:0]  fc;
    logic [15:0] addr;
    logic [15:0] data;
  } tcp_req_t;
  typedef struct packed {
    logic        inst;
    logic [7:0]  fc;
    logic [15:0] addr;
    logic [15:0] data;
  } tcp_rsp_t;
  typedef struct packed {
    logic        vld;
    logic        bcast;
    logic [1:0]  src;
    logic [7:0]  fc;
    logic [15:0] addr;
    logic [15:0] data;
  } job_t;
  typedef struct packed {
    logic [15:0] msg;
    logic [15:0] err;
    logic [15:0] tout;
  } cnt_t;
  typedef struct packed {
    logic [7:0] station; logic [2:0] baud; parity_t parity; proto_t serProto;
    proto_t [1:0] ethProto; logic [1:0][15:0] ethPort;
    cnt_t [2:0] cnt; logic [15:0][15:0] hold;
    logic ack; logic [31:0] rdat;
    rx_t rx; logic [23:0] rxTmr; logic [3:0] rxIdx; logic [7:0] rxSh; logic rxBad;
    logic [23:0] idle; logic [3:0] fcnt; logic fErr; logic [15:0] fCrc;
    logic [7:0][7:0] fbuf;
    tx_t tx; logic [23:0] txTmr; logic [3:0] txBit; logic [10:0] txSh;
    logic [3:0] txPos; logic [3:0] txLen; logic [15:0] txCrc; logic [7:0][7:0] txBuf;
    logic txd; logic txEn;
    logic rspV; tcp_rsp_t rsp; logic [23:0] rspTmr;
  } state_t;
endpackage

// *** sim/mb_master_model.sv ***
module mb_master_model #(
  parameter int BitCyc = 52,  // Clock cycles per bit.
  parameter int GapCyc = 2100 // Line silence before each query.
) (
  input  wire logic       mclk,    // System clock.
  input  wire logic [1:0] parMode, // 0 none, 1 even, 2 odd.
  output logic            rtuRxd,  // Line into the slave.
  input  wire logic       rtuTxd,  // Line out of the slave.
  input  wire logic       rtuTxEn  // Slave driver enable.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] txFrame[8];
  logic [7:0] rxBytes[$];
  initial rtuRxd = 1'b1;
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction
  function automatic logic parBit(input logic [7:0] b);
    return (parMode == 2'h2) ? ~^b : ^b;
  endfunction
  task automatic sendChar(input logic [7:0] b);
    logic [10:0] bits;
    bits = (parMode == 2'h0) ? {2'b11, b, 1'b0} : {1'b1, parBit(b), b, 1'b0};
    for (int i = 0; i < ((parMode == 2'h0) ? 10 : 11); i++) begin
      rtuRxd <= bits[i];
      repeat (BitCyc) @(posedge mclk);
    end
  endtask
  // Only this side opens a transaction, and only after a full line silence.
  task automatic sendReq(input logic [7:0] adr, fc, input logic [15:0] regAdr, val,
                         input logic badCrc);
    logic [7:0] q[$];
    logic [15:0] c;
    q = {adr, fc, regAdr[15:8], regAdr[7:0], val[15:8], val[7:0]};
    c = crc16(q) ^ {15'h0, badCrc};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) txFrame[i] = q[i];
    repeat (GapCyc) @(posedge mclk);
    foreach (q[i]) sendChar(q[i]);
  endtask
  // A character with a wrong parity bit is stored as unknown so that no compare passes it.
  task automatic recvReply(input int nBytes, output int got);
    logic [7:0] b;
    int n;
    rxBytes.delete();
    got = 0;
    for (n = 0; rtuTxEn !== 1'b1 && n < 3000; n++) @(posedge mclk);
    if (n >= 3000) return;
    for (int j = 0; j < nBytes; j++) begin
      for (n = 0; rtuTxd !== 1'b0 && n < 20 * BitCyc; n++) @(posedge mclk);
      repeat (BitCyc / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BitCyc) @(posedge mclk);
        b[i] = rtuTxd;
      end
      repeat (BitCyc) @(posedge mclk);
      if (parMode != 2'h0 && rtuTxd !== parBit(b)) b = 'x;
      if (parMode != 2'h0) repeat (BitCyc) @(posedge mclk);
      rxBytes.push_back(b);
      got++;
    end
  endtask
endmodule

// *** sim/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mb_pkg::*;
  localparam int ClkHz = 1000000;
  localparam int BitCyc = ClkHz / 19200;
  logic        mclk, rstn, wbCyc, wbStb, wbWe, wbAck, iecOption, rtuRxd, rtuTxd, rtuTxEn;
  logic        tcpReqValid, tcpReqReady, tcpRspValid, tcpRspReady, seen;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatI, wbDatO, rd;
  logic [1:0]  parMode;
  logic [15:0] val;
  logic [7:0]  exp[$];
  tcp_req_t    tcpReq;
  tcp_rsp_t    tcpRsp;
  int          errors, totalChecks, got;
  int          cycles = 0;
  modbus_slave_fe #(.ClkHz(ClkHz), .TcpToutUs(100)) modbus_slave_fe_inst (
    .mclk(mclk), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
    .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .iecOption(iecOption),
    .rtuRxd(rtuRxd), .rtuTxd(rtuTxd), .rtuTxEn(rtuTxEn), .tcpReqValid(tcpReqValid),
    .tcpReqReady(tcpReqReady), .tcpReq(tcpReq), .tcpRspValid(tcpRspValid),
    .tcpRspReady(tcpRspReady), .tcpRsp(tcpRsp));
  mb_master_model #(.BitCyc(BitCyc)) mb_master_model_inst (
    .mclk(mclk), .parMode(parMode), .rtuRxd(rtuRxd), .rtuTxd(rtuTxd), .rtuTxEn(rtuTxEn));
  always #12.5 mclk = ~mclk;
  task automatic give_verdict();
    if (errors == 0 && totalChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // The ceiling leaves room for six serial transactions at 19200 bit/s.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic compare(input string name, input logic [31:0] expV, gotV);
    totalChecks++;
    if (gotV !== expV) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, expV, gotV);
    end
  endtask
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    for (n = 0; wbAck !== 1'b1 && n < 20; n++) @(posedge mclk);
    rd = wbDatO;
    if (n >= 20) errors++;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  task automatic rdChk(input string name, input logic [7:0] adr, input logic [31:0] expV);
    wbXfer(1'b0, adr, 32'h0);
    compare(name, expV, rd);
  endtask
  task automatic tcpXfer(input logic inst, input logic [15:0] port, input logic [7:0] fc,
                         input logic [15:0] adr, dat, input logic take);
    int n;
    @(posedge mclk);
    tcpReqValid <= 1'b1;
    tcpReq <= '{inst, port, 8'h05, fc, adr, dat};
    n = 0;
    do @(posedge mclk); while (tcpReqReady !== 1'b1 && ++n < 20);
    if (n >= 20) errors++;
    tcpReqValid <= 1'b0;
    seen = 1'b0;
    for (n = 0; n < 4 && !seen; n++) begin
      @(posedge mclk);
      seen = (tcpRspValid === 1'b1);
    end
    val = tcpRsp.data;
    if (seen && take) begin
      tcpRspReady <= 1'b1;
      @(posedge mclk);
      tcpRspReady <= 1'b0;
    end
  endtask
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    {wbCyc, wbStb, wbWe, iecOption, tcpReqValid, tcpRspReady} = 6'h00;
    wbAdr = 8'h00;
    wbSel = 4'hf;
    wbDatI = 32'h0;
    parMode = 2'h0;
    tcpReq = '0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    rdChk("ctrl reset", 8'h00, 32'h00002301);
    rdChk("eth0 reset", 8'h04, 32'h01f60000);
    rdChk("unmapped", 8'hfc, 32'h0);
    wbXfer(1'b1, 8'h00, 32'h000025f8);
    rdChk("ctrl illegal", 8'h00, 32'h00002301);
    wbXfer(1'b1, 8'h00, 32'h00002c05);
    parMode <= 2'h1;
    rdChk("ctrl set", 8'h00, 32'h00002c05);
    wbXfer(1'b1, 8'h04, 32'h00000002);
    rdChk("eth0 iec refused", 8'h04, 32'h01f60000);
    iecOption <= 1'b1;
    for (int p = 0; p < 5; p++) begin
      wbXfer(1'b1, 8'h08, {16'h01f6, 13'h0, p[2:0]});
      rdChk("eth1 proto", 8'h08, {(p == 3) ? 16'haf12 : 16'h01f6, 13'h0, p[2:0]});
    end
    wbXfer(1'b1, 8'h04, 32'h00000001);
    wbXfer(1'b1, 8'h04, 32'h01f70001);
    rdChk("eth0 port", 8'h04, 32'h01f70001);
    tcpXfer(1'b0, 16'h01f6, 8'h06, 16'h0004, 16'hbeef, 1'b1);
    compare("tcp wrong port", 32'h0, {31'h0, seen});
    tcpXfer(1'b1, 16'h01f6, 8'h06, 16'h0004, 16'hbeef, 1'b1);
    compare("tcp proto off", 32'h0, {31'h0, seen});
    tcpXfer(1'b0, 16'h01f7, 8'h06, 16'h0004, 16'hbeef, 1'b1);
    compare("tcp write echo", 32'h1beef, {15'h0, seen, val});
    rdChk("hold 4", 8'h50, 32'h0000beef);
    tcpXfer(1'b0, 16'h01f7, 8'h03, 16'h0004, 16'h0001, 1'b0);
    compare("tcp read", 32'h1beef, {15'h0, seen, val});
    compare("tcp rsp fields", 32'h00030004, {7'h0, tcpRsp.inst, tcpRsp.fc, tcpRsp.addr});
    repeat (300) @(posedge mclk);
    compare("tcp dropped", 32'h0, {31'h0, tcpRspValid});
    rdChk("eth0 timeouts", 8'h28, 32'h1);
    mb_master_model_inst.sendReq(8'h05, 8'h06, 16'h0002, 16'h1234, 1'b0);
    mb_master_model_inst.recvReply(8, got);
    compare("echo length", 32'd8, got);
    foreach (mb_master_model_inst.rxBytes[i])
      compare("echo byte", mb_master_model_inst.txFrame[i], mb_master_model_inst.rxBytes[i]);
    rdChk("hold 2", 8'h48, 32'h1234);
    mb_master_model_inst.sendReq(8'h05, 8'h03, 16'h0002, 16'h0001, 1'b0);
    mb_master_model_inst.recvReply(7, got);
    exp = {8'h05, 8'h03, 8'h02, 8'h12, 8'h34};
    val = mb_master_model_inst.crc16(exp);
    exp.push_back(val[7:0]);
    exp.push_back(val[15:8]);
    compare("read length", 32'd7, got);
    foreach (exp[i]) compare("read byte", exp[i], mb_master_model_inst.rxBytes[i]);
    mb_master_model_inst.sendReq(8'h00, 8'h06, 16'h0003, 16'h00a5, 1'b0);
    mb_master_model_inst.recvReply(8, got);
    compare("broadcast reply", 32'd0, got);
    rdChk("hold 3", 8'h4c, 32'h00a5);
    mb_master_model_inst.sendReq(8'h07, 8'h06, 16'h0003, 16'h0001, 1'b0);
    mb_master_model_inst.recvReply(8, got);
    compare("other address", 32'd0, got);
    mb_master_model_inst.sendReq(8'h05, 8'h06, 16'h0003, 16'h0002, 1'b1);
    mb_master_model_inst.recvReply(8, got);
    compare("bad crc reply", 32'd0, got);
    parMode <= 2'h2;
    mb_master_model_inst.sendReq(8'h05, 8'h06, 16'h0003, 16'h0003, 1'b0);
    mb_master_model_inst.recvReply(8, got);
    compare("parity err reply", 32'd0, got);
    parMode <= 2'h1;
    rdChk("hold 3 kept", 8'h4c, 32'h00a5);
    rdChk("serial msgs", 8'h10, 32'h3);
    rdChk("serial errors", 8'h14, 32'h2);
    give_verdict();
  end
endmodule
